// ==== recorder_pkg.sv ====
/*
 * Constants, field layout and types shared by the measurement data
 * recorder and its trigger timebase.
 * Assumes a 40 MHz system clock and a 32-bit register port.
 */
package recorder_pkg;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int unsigned CLK_NS          = 25;
	localparam int unsigned TICK_NS         = 640;
	localparam longint      MIN_INTERVAL_NS = 64'd9600;
	localparam longint      MAX_INTERVAL_NS = 64'd20000000000;
	localparam longint      MAX_DELAY_NS    = 64'd100000000000;
	localparam int unsigned EXT_MIN_LEVEL_NS = 500;

	localparam int INTERVAL_W = 25;
	localparam int DELAY_W    = 28;
	localparam logic [INTERVAL_W-1:0] MIN_INTERVAL_TICKS =
		INTERVAL_W'(MIN_INTERVAL_NS / TICK_NS);
	localparam logic [INTERVAL_W-1:0] MAX_INTERVAL_TICKS =
		INTERVAL_W'(MAX_INTERVAL_NS / TICK_NS);
	localparam logic [DELAY_W-1:0] MAX_DELAY_TICKS =
		DELAY_W'(MAX_DELAY_NS / TICK_NS);

	localparam logic [9:0] TICK_STEP  = 10'(CLK_NS);
	localparam logic [9:0] TICK_LIMIT = 10'(TICK_NS);
	localparam logic [5:0] EXT_HOLDOFF_CYC =
		6'((2 * EXT_MIN_LEVEL_NS + CLK_NS - 1) / CLK_NS);

	// ------------------------------------------------------------------
	// Capacities and sample layout
	// ------------------------------------------------------------------
	localparam int CAP_W = 17;
	localparam logic [CAP_W-1:0] CAP_MIN    = 17'h00010;
	localparam logic [CAP_W-1:0] CAP12_MAX  = 17'h02000;
	localparam logic [CAP_W-1:0] CAP3_MAX   = 17'h10000;
	localparam logic [2:0]       MAX_WORDS  = 3'h5;
	localparam logic [2:0]       SRC_LAST   = 3'h6;
	localparam int               SEL_FREQ   = 5;
	localparam int               FLAG_COUNT = 5;

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_SELECT    = 8'h04;
	localparam logic [7:0] OFS_INTERVAL  = 8'h08;
	localparam logic [7:0] OFS_DELAY     = 8'h0C;
	localparam logic [7:0] OFS_CAP1      = 8'h10;
	localparam logic [7:0] OFS_CAP2      = 8'h14;
	localparam logic [7:0] OFS_CAP3      = 8'h18;
	localparam logic [7:0] OFS_CMD       = 8'h1C;
	localparam logic [7:0] OFS_IRQ_STAT  = 8'h20;
	localparam logic [7:0] OFS_IRQ_MASK  = 8'h24;
	localparam logic [7:0] OFS_COUNT1    = 8'h28;
	localparam logic [7:0] OFS_COUNT2    = 8'h2C;
	localparam logic [7:0] OFS_FIFO_LVL  = 8'h30;
	localparam logic [7:0] OFS_FIFO_RD   = 8'h34;
	localparam logic [7:0] OFS_LIVE      = 8'h38;

	localparam int CTRL_ARM      = 0;
	localparam int CTRL_BUF_LSB  = 1;
	localparam int CTRL_MODE_LSB = 3;
	localparam int CMD_REMOTE    = 0;
	localparam int CMD_REARM1    = 1;
	localparam int CMD_REARM2    = 2;
	localparam int CMD_FIFO_POP  = 3;
	localparam int CMD_FIFO_CLR  = 4;
	localparam int IRQ_DONE      = 0;
	localparam int IRQ_FULL1     = 1;
	localparam int IRQ_FULL2     = 2;
	localparam int IRQ_OVERFLOW  = 3;
	localparam int IRQ_MISSED    = 4;
	localparam int IRQ_W         = 5;

	localparam logic [4:0]  CTRL_RST   = 5'h00;
	localparam logic [5:0]  SELECT_RST = 6'h01;
	localparam logic [IRQ_W-1:0] IRQ_RST = 5'h00;

	typedef enum logic [1:0] {BUF_ONE, BUF_TWO, BUF_FIFO, BUF_NONE} buf_sel_t;
	typedef enum logic [1:0] {
		TRIG_TIMER, TRIG_EXT, TRIG_REMOTE, TRIG_MANUAL
	} trig_mode_t;

	// Words one selection occupies; the frequency takes two
	function automatic logic [2:0] word_count(input logic [5:0] sel);
		logic [2:0] n;
		n = 3'h0;
		for (int i = 0; i < 6; i++)
		begin
			if (sel[i])
				n = n + ((i == SEL_FREQ) ? 3'h2 : 3'h1);
		end
		return n;
	endfunction

endpackage

// ==== trig_timebase.sv ====
/*
 * 640 ns timebase and external trigger input conditioning.
 * Assumes the trigger pin is asynchronous to clk_sys.
 */
`timescale 1ns/100ps
module trig_timebase
	import recorder_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	input  wire logic external_trigger_pin,
	output logic      tick,
	output logic      ext_fall
);

	logic [9:0] acc_reg;
	logic       sync1_reg;
	logic       sync2_reg;
	logic       prev_reg;
	logic [5:0] holdoff_reg;
	logic       fall_now;

	// ------------------------------------------------------------------
	// Fractional tick: average period exactly 640 ns
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			acc_reg <= 10'h000;
		else if (acc_reg + TICK_STEP >= TICK_LIMIT) // see RULE8
			acc_reg <= acc_reg + TICK_STEP - TICK_LIMIT;
		else
			acc_reg <= acc_reg + TICK_STEP;
	end

	assign tick = (acc_reg + TICK_STEP >= TICK_LIMIT);

	// ------------------------------------------------------------------
	// Pin synchroniser and falling edge
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
			prev_reg  <= 1'b1;
		end
		else
		begin
			sync1_reg <= external_trigger_pin;
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg;
		end
	end

	assign fall_now = prev_reg && !sync2_reg && (holdoff_reg == 6'h00);

	// Edges closer than one full high plus low period are noise
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			holdoff_reg <= 6'h00;
		else if (fall_now)
			holdoff_reg <= EXT_HOLDOFF_CYC; // see RULE9
		else if (holdoff_reg != 6'h00)
			holdoff_reg <= holdoff_reg - 6'h01;
	end

	assign ext_fall = fall_now; // see RULE9

	tick_gap_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		tick |=> !tick [*8]) else $error("ticks too close"); // see RULE8
	fall_edge_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		ext_fall |-> $past(sync2_reg) && !sync2_reg ##1 !ext_fall [*8])
		else $error("trigger not on falling edge"); // see RULE9

endmodule

// ==== measurement_data_recorder.sv ====
/*
 * Triggered sample recorder: on each trigger, after a delay, writes one
 * sample of up to five selected words into buffer 1, 2 or the FIFO.
 * Assumes measurement inputs and the manual trigger are on clk_sys and
 * that sample storage sits behind the mem_* write port.
 */
// Chosen here: the strobed register port and the address map.
// Contract
// RULE1 - Sample holds at most five selected words
// RULE2 - Status, data words 16 bit; frequency two
// RULE3 - Status word carries five overload/unlock flags
// RULE4 - Buffers one, two hold 16 to 8192
// RULE5 - Third buffer is FIFO, 16 to 65536
// RULE6 - One sample per trigger, four sources
// RULE7 - Timer triggers every 9.6us-20s, 640ns steps
// RULE8 - Other triggers >=10us apart, jitter 640ns
// RULE9 - External pin falling edge, 500ns levels
// RULE10 - Delay 0-100s in 640ns before write
// RULE11 - Configuration remote only; panel manual trigger
// RULE12 - Full buffer ignores triggers until rearmed
`timescale 1ns/100ps
module measurement_data_recorder
	import recorder_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	output logic             irq,
	input  wire logic        external_trigger_pin,
	input  wire logic        manual_trigger,
	input  wire logic        flag_ref_unlock,
	input  wire logic        flag_input_protect,
	input  wire logic        flag_pre_detector_ovl,
	input  wire logic        flag_post_detector_ovl,
	input  wire logic        flag_aux_ovl,
	input  wire logic [15:0] data1,
	input  wire logic [15:0] data2,
	input  wire logic [15:0] data3,
	input  wire logic [15:0] data4,
	input  wire logic [31:0] ref_freq,
	output logic             mem_wr,
	output logic      [1:0]  mem_buffer,
	output logic      [15:0] mem_sample,
	output logic      [2:0]  mem_word,
	output logic      [15:0] mem_data
);
	import recorder_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_EMIT} state_t;

	state_t                  state_reg;
	logic [4:0]              ctrl_reg;
	logic [5:0]              select_reg;
	logic [INTERVAL_W-1:0]   interval_reg;
	logic [DELAY_W-1:0]      delay_reg;
	logic [CAP_W-1:0]        cap1_reg;
	logic [CAP_W-1:0]        cap2_reg;
	logic [CAP_W-1:0]        cap3_reg;
	logic [IRQ_W-1:0]        irq_stat_reg;
	logic [IRQ_W-1:0]        irq_mask_reg;
	logic [CAP_W-1:0]        count1_reg;
	logic [CAP_W-1:0]        count2_reg;
	logic [15:0]             fifo_wr_reg;
	logic [15:0]             fifo_rd_reg;
	logic [CAP_W-1:0]        fifo_lvl_reg;
	logic [INTERVAL_W-1:0]   timer_reg;
	logic [DELAY_W-1:0]      dcnt_reg;
	logic [2:0]              src_reg;
	logic [2:0]              slot_reg;
	buf_sel_t                target_reg;
	logic [15:0]             snap_status_reg;
	logic [15:0]             snap_data_reg [4];
	logic [31:0]             snap_freq_reg;

	logic       tick;
	logic       ext_fall;
	logic       wr_cmd;
	logic       timer_fire;
	logic       trig;
	logic       target_full;
	logic       accept;
	logic       capture;
	logic       sample_done;
	logic       src_sel;
	logic [15:0] src_word;
	logic [IRQ_W-1:0] irq_set;
	buf_sel_t   buf_sel;
	trig_mode_t trig_mode;
	logic [4:0] flags;

	trig_timebase timebase (
		.clk_sys              (clk_sys),
		.sys_rst              (sys_rst),
		.external_trigger_pin (external_trigger_pin),
		.tick                 (tick),
		.ext_fall             (ext_fall)
	);

	// Keep a written capacity inside the documented span
	function automatic logic [CAP_W-1:0] clamp_cap(
		input logic [31:0]      v,
		input logic [CAP_W-1:0] hi
	);
		if (v < 32'(CAP_MIN))
			return CAP_MIN;
		else if (v > 32'(hi))
			return hi;
		else
			return v[CAP_W-1:0];
	endfunction

	// ------------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------------
	assign buf_sel   = buf_sel_t'(ctrl_reg[CTRL_BUF_LSB +: 2]);
	assign trig_mode = trig_mode_t'(ctrl_reg[CTRL_MODE_LSB +: 2]);
	assign wr_cmd    = reg_wr && (reg_addr == OFS_CMD);

	// Only the register port reaches configuration; the panel cannot
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ctrl_reg     <= CTRL_RST;
			select_reg   <= SELECT_RST;
			interval_reg <= MIN_INTERVAL_TICKS;
			delay_reg    <= '0;
			cap1_reg     <= CAP_MIN;
			cap2_reg     <= CAP_MIN;
			cap3_reg     <= CAP_MIN;
			irq_mask_reg <= IRQ_RST;
		end
		else if (reg_wr) // see RULE11
		begin
			case (reg_addr)
				OFS_CTRL:
					ctrl_reg <= reg_wdata[4:0];
				OFS_SELECT:
					if (word_count(reg_wdata[5:0]) <= MAX_WORDS) // see RULE1
						select_reg <= reg_wdata[5:0];
				OFS_INTERVAL:
					if (reg_wdata < 32'(MIN_INTERVAL_TICKS)) // see RULE7
						interval_reg <= MIN_INTERVAL_TICKS;
					else if (reg_wdata > 32'(MAX_INTERVAL_TICKS))
						interval_reg <= MAX_INTERVAL_TICKS;
					else
						interval_reg <= reg_wdata[INTERVAL_W-1:0];
				OFS_DELAY:
					if (reg_wdata > 32'(MAX_DELAY_TICKS)) // see RULE10
						delay_reg <= MAX_DELAY_TICKS;
					else
						delay_reg <= reg_wdata[DELAY_W-1:0];
				OFS_CAP1:
					cap1_reg <= clamp_cap(reg_wdata, CAP12_MAX); // see RULE4
				OFS_CAP2:
					cap2_reg <= clamp_cap(reg_wdata, CAP12_MAX); // see RULE4
				OFS_CAP3:
					cap3_reg <= clamp_cap(reg_wdata, CAP3_MAX); // see RULE5
				OFS_IRQ_MASK:
					irq_mask_reg <= reg_wdata[IRQ_W-1:0];
				default:
					;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Trigger sources
	// ------------------------------------------------------------------
	assign timer_fire = ctrl_reg[CTRL_ARM] && (trig_mode == TRIG_TIMER) &&
		tick && (timer_reg == '0);

	// Timer counts ticks; reloading on fire keeps intervals equal
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			timer_reg <= '0;
		else if (!ctrl_reg[CTRL_ARM] || trig_mode != TRIG_TIMER)
			timer_reg <= '0;
		else if (timer_fire)
			timer_reg <= interval_reg - 1'b1; // see RULE7
		else if (tick)
			timer_reg <= timer_reg - 1'b1;
	end

	always_comb
	begin
		case (trig_mode) // see RULE6
			TRIG_TIMER:  trig = timer_fire;
			TRIG_EXT:    trig = ext_fall;
			TRIG_REMOTE: trig = wr_cmd && reg_wdata[CMD_REMOTE];
			TRIG_MANUAL: trig = manual_trigger;
			default:     trig = 1'b0;
		endcase
	end

	always_comb
	begin
		case (buf_sel)
			BUF_ONE:  target_full = (count1_reg >= cap1_reg); // see RULE12
			BUF_TWO:  target_full = (count2_reg >= cap2_reg); // see RULE12
			BUF_FIFO: target_full = (fifo_lvl_reg >= cap3_reg);
			default:  target_full = 1'b1;
		endcase
	end

	assign accept = trig && ctrl_reg[CTRL_ARM] && !target_full &&
		(state_reg == ST_IDLE);

	// ------------------------------------------------------------------
	// Delay, capture and word emission
	// ------------------------------------------------------------------
	// The delay runs on ticks, so sampling lands within one tick of
	// the trigger plus the programmed delay
	assign capture = (state_reg == ST_DELAY) && tick && (dcnt_reg == '0);
	assign sample_done = (state_reg == ST_EMIT) && (src_reg == SRC_LAST);

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_reg  <= ST_IDLE;
			dcnt_reg   <= '0;
			src_reg    <= 3'h0;
			slot_reg   <= 3'h0;
			target_reg <= BUF_ONE;
		end
		else
		begin
			case (state_reg)
				ST_IDLE:
					if (accept) // see RULE6
					begin
						dcnt_reg   <= delay_reg; // see RULE10
						target_reg <= buf_sel;
						state_reg  <= ST_DELAY;
					end
				ST_DELAY:
					if (capture) // see RULE8
					begin
						src_reg   <= 3'h0;
						slot_reg  <= 3'h0;
						state_reg <= ST_EMIT;
					end
					else if (tick)
						dcnt_reg <= dcnt_reg - 1'b1; // see RULE10
				ST_EMIT:
				begin
					src_reg <= src_reg + 3'h1;
					if (src_sel)
						slot_reg <= slot_reg + 3'h1;
					if (sample_done)
						state_reg <= ST_IDLE;
				end
				default:
					state_reg <= ST_IDLE;
			endcase
		end
	end

	assign flags = {flag_aux_ovl, flag_post_detector_ovl,
		flag_pre_detector_ovl, flag_input_protect, flag_ref_unlock};

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			snap_status_reg <= 16'h0000;
			snap_freq_reg   <= 32'h00000000;
			for (int i = 0; i < 4; i++)
				snap_data_reg[i] <= 16'h0000;
		end
		else if (capture)
		begin
			snap_status_reg <= {11'h000, flags}; // see RULE3
			snap_data_reg[0] <= data1;
			snap_data_reg[1] <= data2;
			snap_data_reg[2] <= data3;
			snap_data_reg[3] <= data4;
			snap_freq_reg   <= ref_freq;
		end
	end

	// Sources 0..6: status, data1..4, frequency high, frequency low
	always_comb
	begin
		src_sel  = 1'b0;
		src_word = 16'h0000;
		case (src_reg)
			3'h0:
			begin
				src_sel  = select_reg[0];
				src_word = snap_status_reg;
			end
			3'h1, 3'h2, 3'h3, 3'h4:
			begin
				src_sel  = select_reg[src_reg];
				src_word = snap_data_reg[src_reg[1:0] - 2'h1];
			end
			3'h5:
			begin
				src_sel  = select_reg[SEL_FREQ];
				src_word = snap_freq_reg[31:16]; // see RULE2
			end
			3'h6:
			begin
				src_sel  = select_reg[SEL_FREQ];
				src_word = snap_freq_reg[15:0]; // see RULE2
			end
			default:
				src_sel = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			mem_wr     <= 1'b0;
			mem_buffer <= 2'h0;
			mem_sample <= 16'h0000;
			mem_word   <= 3'h0;
			mem_data   <= 16'h0000;
		end
		else
		begin
			mem_wr     <= (state_reg == ST_EMIT) && src_sel; // see RULE1
			mem_buffer <= target_reg;
			mem_word   <= slot_reg;
			mem_data   <= src_word;
			case (target_reg)
				BUF_ONE:  mem_sample <= count1_reg[15:0];
				BUF_TWO:  mem_sample <= count2_reg[15:0];
				default:  mem_sample <= fifo_wr_reg;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Fill counts and FIFO pointers
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			count1_reg <= '0;
			count2_reg <= '0;
		end
		else
		begin
			if (sample_done && target_reg == BUF_ONE)
				count1_reg <= count1_reg + 1'b1; // see RULE6
			else if (wr_cmd && reg_wdata[CMD_REARM1])
				count1_reg <= '0; // see RULE12
			if (sample_done && target_reg == BUF_TWO)
				count2_reg <= count2_reg + 1'b1; // see RULE6
			else if (wr_cmd && reg_wdata[CMD_REARM2])
				count2_reg <= '0; // see RULE12
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			fifo_wr_reg  <= 16'h0000;
			fifo_rd_reg  <= 16'h0000;
			fifo_lvl_reg <= '0;
		end
		else if (wr_cmd && reg_wdata[CMD_FIFO_CLR])
		begin
			fifo_wr_reg  <= 16'h0000;
			fifo_rd_reg  <= 16'h0000;
			fifo_lvl_reg <= '0;
		end
		else
		begin
			if (sample_done && target_reg == BUF_FIFO) // see RULE5
				fifo_wr_reg <= fifo_wr_reg + 16'h0001;
			if (wr_cmd && reg_wdata[CMD_FIFO_POP] && fifo_lvl_reg != '0)
				fifo_rd_reg <= fifo_rd_reg + 16'h0001;
			fifo_lvl_reg <= fifo_lvl_reg
				+ CAP_W'(sample_done && target_reg == BUF_FIFO)
				- CAP_W'(wr_cmd && reg_wdata[CMD_FIFO_POP] &&
					fifo_lvl_reg != '0);
		end
	end

	// ------------------------------------------------------------------
	// Interrupts and read port
	// ------------------------------------------------------------------
	assign irq_set[IRQ_DONE]     = sample_done;
	assign irq_set[IRQ_FULL1]    = trig && ctrl_reg[CTRL_ARM] &&
		buf_sel == BUF_ONE && target_full;
	assign irq_set[IRQ_FULL2]    = trig && ctrl_reg[CTRL_ARM] &&
		buf_sel == BUF_TWO && target_full;
	assign irq_set[IRQ_OVERFLOW] = trig && ctrl_reg[CTRL_ARM] &&
		buf_sel == BUF_FIFO && target_full;
	assign irq_set[IRQ_MISSED]   = trig && ctrl_reg[CTRL_ARM] &&
		!target_full && state_reg != ST_IDLE;

	// A new event wins over a write-one clear in the same cycle
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			irq_stat_reg <= IRQ_RST;
		else if (reg_wr && reg_addr == OFS_IRQ_STAT)
			irq_stat_reg <= (irq_stat_reg & ~reg_wdata[IRQ_W-1:0]) | irq_set;
		else
			irq_stat_reg <= irq_stat_reg | irq_set;
	end

	assign irq = |(irq_stat_reg & irq_mask_reg);

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			reg_rdata <= 32'h00000000;
		else if (!reg_rd)
			reg_rdata <= 32'h00000000;
		else
		begin
			case (reg_addr)
				OFS_CTRL:     reg_rdata <= 32'(ctrl_reg);
				OFS_SELECT:   reg_rdata <= 32'(select_reg);
				OFS_INTERVAL: reg_rdata <= 32'(interval_reg);
				OFS_DELAY:    reg_rdata <= 32'(delay_reg);
				OFS_CAP1:     reg_rdata <= 32'(cap1_reg);
				OFS_CAP2:     reg_rdata <= 32'(cap2_reg);
				OFS_CAP3:     reg_rdata <= 32'(cap3_reg);
				OFS_IRQ_STAT: reg_rdata <= 32'(irq_stat_reg);
				OFS_IRQ_MASK: reg_rdata <= 32'(irq_mask_reg);
				OFS_COUNT1:   reg_rdata <= 32'(count1_reg);
				OFS_COUNT2:   reg_rdata <= 32'(count2_reg);
				OFS_FIFO_LVL: reg_rdata <= 32'(fifo_lvl_reg);
				OFS_FIFO_RD:  reg_rdata <= 32'(fifo_rd_reg);
				OFS_LIVE:     reg_rdata <= {24'h000000, 1'b0, state_reg, flags};
				default:      reg_rdata <= 32'h00000000;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	word_limit_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		word_count(select_reg) <= MAX_WORDS &&
		(!mem_wr || mem_word < MAX_WORDS))
		else $error("more than five words selected"); // see RULE1
	freq_split_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		state_reg == ST_EMIT && src_reg == 3'h5 && src_sel |=>
		mem_wr && mem_data == snap_freq_reg[31:16] ##1
		mem_wr && mem_data == snap_freq_reg[15:0])
		else $error("frequency words wrong"); // see RULE2
	status_flags_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		capture |=> snap_status_reg == {11'h000, $past(flags)})
		else $error("status snapshot wrong"); // see RULE3
	cap_span_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		cap1_reg >= CAP_MIN && cap1_reg <= CAP12_MAX &&
		cap2_reg >= CAP_MIN && cap2_reg <= CAP12_MAX)
		else $error("buffer capacity out of span"); // see RULE4
	fifo_bound_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		fifo_lvl_reg <= CAP3_MAX && (fifo_lvl_reg <= cap3_reg ||
		fifo_lvl_reg <= $past(fifo_lvl_reg)))
		else $error("fifo level beyond capacity"); // see RULE5
	one_sample_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		sample_done && target_reg == BUF_ONE |=>
		count1_reg == $past(count1_reg) + 1'b1 && state_reg == ST_IDLE)
		else $error("sample count not advanced by one"); // see RULE6
	timer_reload_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		timer_fire && !reg_wr |=> timer_reg == interval_reg - 1'b1)
		else $error("timer interval not reloaded"); // see RULE7
	delay_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		state_reg == ST_DELAY && dcnt_reg != '0 |=> state_reg == ST_DELAY)
		else $error("sample taken before delay elapsed"); // see RULE10
	full_stop_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		count1_reg >= cap1_reg && !(wr_cmd && reg_wdata[CMD_REARM1]) &&
		buf_sel == BUF_ONE |-> !accept)
		else $error("full buffer accepted a trigger"); // see RULE12

endmodule

// ==== trig_source.sv ====
/*
 * Model of the external trigger source.
 * Assumes clk_sys at 40 MHz and one fire pulse per trigger.
 */
`timescale 1ns/100ps
module trig_source
(
	input  wire logic clk_sys,
	input  wire logic fire,
	output logic      external_trigger_pin
);
	initial external_trigger_pin = 1'b1;
	// Each level held 24 cycles, 600 ns
	always @(posedge clk_sys)
	begin
		if (fire)
		begin
			external_trigger_pin <= 1'b0;
			repeat (24) @(posedge clk_sys);
			external_trigger_pin <= 1'b1;
			repeat (24) @(posedge clk_sys);
		end
	end
endmodule

// ==== measurement_data_recorder_test.sv ====
/*
 * Self-checking bench for the recorder.
 * Assumes trig_source drives the trigger pin.
 */
`timescale 1ns/100ps
module measurement_data_recorder_test;
	import recorder_pkg::*;
	logic        clk_sys = '0, sys_rst = '1, reg_wr = '0, reg_rd = '0;
	logic        manual_trigger = '0, fire = '0, irq, mem_wr;
	logic        external_trigger_pin;
	logic [7:0]  reg_addr = '0;
	logic [31:0] reg_wdata = '0, ref_freq = '0, reg_rdata, rd;
	logic [31:0] rnd = 32'h33DA;
	logic [15:0] data1 = '0, data2 = '0, data3 = '0, data4 = '0;
	logic [15:0] mem_data, mem_sample;
	logic [4:0]  flags = '0;
	logic [2:0]  mem_word;
	logic [1:0]  mem_buffer;
	int          fail_count = 0, samples_checked = 0;
	time         t0;

	always #12.5 clk_sys = ~clk_sys;

	measurement_data_recorder uut (.clk_sys, .sys_rst, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
		.external_trigger_pin, .manual_trigger,
		.flag_ref_unlock(flags[0]), .flag_input_protect(flags[1]),
		.flag_pre_detector_ovl(flags[2]),
		.flag_post_detector_ovl(flags[3]), .flag_aux_ovl(flags[4]),
		.data1, .data2, .data3, .data4, .ref_freq, .mem_wr,
		.mem_buffer, .mem_sample, .mem_word, .mem_data);
	trig_source partner (.clk_sys, .fire, .external_trigger_pin);

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	// Source words in emit order
	function automatic logic [15:0] src(input int i);
		logic [15:0] v[7];
		v = '{{11'h000, flags}, data1, data2, data3, data4,
			ref_freq[31:16], ref_freq[15:0]};
		return v[i];
	endfunction

	task automatic conclude;
		$display("checked %0d failed %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	task automatic chk(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 rd = reg_rdata;
		cmp(rd, e);
	endtask

	task automatic word(input logic [1:0] b, input logic [2:0] w,
		input logic [15:0] e, input logic [15:0] s);
		int n;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			#1 n++;
		end
		while (mem_wr !== 1'b1 && n < 2000);
		cmp({mem_wr, mem_buffer, mem_word, mem_data},
			{1'b1, b, w, e});
		cmp(mem_sample, s);
	endtask

	task automatic rec(input logic [5:0] sel, input logic [1:0] b,
		input logic [15:0] s);
		logic [2:0] w;
		w = '0;
		for (int i = 0; i < 7; i++)
			if (sel[i > 5 ? 5 : i])
			begin
				word(b, w, src(i), s);
				w++;
			end
		repeat (400) @(posedge clk_sys);
	endtask

	// Fresh random inputs, then one trigger of kind m
	task automatic shot(input logic [1:0] m);
		rnd = xs(rnd);
		data1 <= rnd[15:0];
		data2 <= rnd[31:16];
		flags <= rnd[4:0];
		rnd = xs(rnd);
		data3 <= rnd[15:0];
		data4 <= rnd[31:16];
		rnd = xs(rnd);
		ref_freq <= rnd;
		@(posedge clk_sys);
		case (m)
			2'h2: wr(OFS_CMD, 32'h00000001);
			2'h3: manual_trigger <= 1'b1;
			default: fire <= 1'b1;
		endcase
		@(posedge clk_sys);
		manual_trigger <= 1'b0;
		fire <= 1'b0;
	endtask

	initial
	begin
		#500000;
		fail_count++;
		conclude();
	end

	initial
	begin
		repeat (3) @(posedge clk_sys);
		sys_rst <= 1'b0;
		chk(OFS_SELECT, 32'h1);
		chk(OFS_INTERVAL, 32'hF);
		chk(OFS_CAP1, 32'h10);
		chk(8'h3C, 32'h0);
		wr(OFS_SELECT, 32'h3F);
		chk(OFS_SELECT, 32'h1);
		wr(OFS_CAP3, 32'h20000);
		chk(OFS_CAP3, 32'h10000);
		wr(OFS_CAP2, 32'h2001);
		chk(OFS_CAP2, 32'h2000);
		wr(OFS_IRQ_MASK, 32'h1);
		wr(OFS_SELECT, 32'h21);
		wr(OFS_CTRL, 32'h11);
		shot(2'h2);
		rec(6'h21, 2'h0, 16'h0);
		chk(OFS_IRQ_STAT, 32'h1);
		cmp(irq, 1'b1);
		wr(OFS_IRQ_MASK, 32'h0);
		#1 cmp(irq, 1'b0);
		wr(OFS_IRQ_MASK, 32'h1);
		#1 cmp(irq, 1'b1);
		wr(OFS_IRQ_STAT, 32'h1);
		#1 cmp(irq, 1'b0);
		wr(OFS_SELECT, 32'h1F);
		wr(OFS_CTRL, 32'h1B);
		shot(2'h3);
		rec(6'h1F, 2'h1, 16'h0);
		wr(OFS_SELECT, 32'h3);
		wr(OFS_CTRL, 32'hD);
		shot(2'h1);
		rec(6'h03, 2'h2, 16'h0);
		chk(OFS_FIFO_LVL, 32'h1);
		wr(OFS_DELAY, 32'h5);
		wr(OFS_SELECT, 32'h1);
		wr(OFS_CTRL, 32'h5);
		t0 = $time;
		word(2'h2, 3'h0, src(0), 16'h1);
		cmp($time - t0 >= 5 * TICK_NS &&
			$time - t0 <= 8 * TICK_NS, 1'b1);
		t0 = $time;
		word(2'h2, 3'h0, src(0), 16'h2);
		cmp(32'($time - t0), 32'(MIN_INTERVAL_NS));
		wr(OFS_CTRL, 32'h4);
		wr(OFS_DELAY, 32'h0);
		wr(OFS_CMD, 32'h8);
		chk(OFS_FIFO_LVL, 32'h2);
		chk(OFS_FIFO_RD, 32'h1);
		wr(OFS_CMD, 32'h10);
		chk(OFS_FIFO_LVL, 32'h0);
		wr(OFS_SELECT, 32'h1);
		wr(OFS_CTRL, 32'h11);
		for (int i = 1; i < 16; i++)
		begin
			shot(2'h2);
			rec(6'h01, 2'h0, 16'(i));
		end
		shot(2'h2);
		chk(OFS_COUNT1, 32'h10);
		chk(OFS_IRQ_STAT, 32'h3);
		wr(OFS_CMD, 32'h2);
		chk(OFS_COUNT1, 32'h0);
		conclude();
	end
endmodule
